// ===== epc_map.svh
// Register map, field positions and reset values of the E1 counter bank.
// Assumes byte addressing on a 32-bit AHB-Lite bus, one register per word.
//
// Operation
// - Keep a 16-bit excessive-zero count, read as upper and lower bytes.
// - Host reads clear counter bits; every counter is zero after reset.
// - Upper read then lower read clears the whole 16-bit count.
// - 8-bit read-clear count of controller 2 check-sequence errors.
// - 8-bit read-clear count of controller 3 check-sequence errors.
// - Summary bit 7 is high while the spare-bit-6 block has a request.
// - Spare-bit-6 summary bit drops once its own status register is read.
// - Summary bit 5 shows clock loss, only with clock-loss detection on.
// - Summary bit 4 is high while the one-second interrupt is declared.
// - Summary bit 3 follows any pending data-link controller request.
// - Summary bit 2 follows the slip-buffer block's pending request.
// - Summary bit 1 follows the alarm and error block's pending request.
// - Summary bit 0 follows the framer block's pending request.
// - Flag sources interrupt only with block and source enables set; bits 5 and 4 need no source enable (bit 5 needs detection on), counter events a mask bit.
`ifndef EPC_MAP_SVH
`define EPC_MAP_SVH

`define EPC_ADDR_W 16
`define EPC_ADDR_ZV_UPPER 16'h0910
`define EPC_ADDR_ZV_LOWER 16'h0914
`define EPC_ADDR_FCS2 16'h091c
`define EPC_ADDR_FCS3 16'h092c
`define EPC_ADDR_SUMMARY 16'h0930
`define EPC_ADDR_BLK_EN 16'h0934
`define EPC_ADDR_INT_STAT 16'h0938
`define EPC_ADDR_INT_MASK 16'h093c
`define EPC_ADDR_CTRL 16'h0940

`define EPC_BIT_SPARE6 7
`define EPC_BIT_RSVD 6
`define EPC_BIT_CLKLOS 5
`define EPC_BIT_ONE_SEC 4
`define EPC_BIT_HDLC 3
`define EPC_BIT_SLIP 2
`define EPC_BIT_ALARM 1
`define EPC_BIT_FRAMER 0

`define EPC_EV_ZV 0
`define EPC_EV_FCS2 1
`define EPC_EV_FCS3 2
`define EPC_EV_W 3

`define EPC_CTRL_CLKLOS_DET 0

`define EPC_RST_BYTE 8'h00
`define EPC_RST_EV 3'h0
`define EPC_RST_WORD 32'h0000_0000
`define EPC_ZV_WIDTH 16
`define EPC_FCS_WIDTH 8

`endif

// ===== epc_pkg.sv
// Shared types of the E1 counter bank.
// Assumes the map header is included by every file that needs addresses.
package epc_pkg;
  typedef logic [7:0] epc_byte_type;
  typedef enum logic {EPC_SEQ_IDLE, EPC_SEQ_UPPER_DONE} epc_seq_type;
endpackage

// ===== epc_cnt_if.sv
// Carrier between the bank and one read-clear counter.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface epc_cnt_if #(parameter int WIDTH = 8);
  logic inc;
  logic clr;
  logic [WIDTH-1:0] count;
  modport owner(input inc, input clr, output count);
  modport user(output inc, output clr, input count);
endinterface
`default_nettype wire

// ===== epc_rur_counter.sv
// Saturating event counter cleared by a host read.
// Assumes inc and clr are single-cycle strobes on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module epc_rur_counter #(
  parameter int WIDTH = 8
) (
  input wire logic sys_clk,
  input wire logic reset,
  epc_cnt_if.owner cnt
);
  import epc_pkg::*;

  localparam logic [WIDTH-1:0] MAXV = {WIDTH{1'b1}};
  localparam logic [WIDTH-1:0] ONE = {{(WIDTH-1){1'b0}}, 1'b1};

  if (WIDTH < 2 || WIDTH > 32) begin : g_check
    $error("epc_rur_counter: WIDTH must lie between 2 and 32");
  end

  // ----------------------------------------------------------------
  // Counting
  // ----------------------------------------------------------------
  // An event in the clearing cycle is kept as a count of one
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cnt.count <= '0;
    end else if (cnt.clr) begin
      cnt.count <= cnt.inc ? ONE : '0;
    end else if (cnt.inc && cnt.count != MAXV) begin
      cnt.count <= cnt.count + ONE;
    end
  end

  a_clear_zero: assert property (
    @(posedge sys_clk) disable iff (reset)
    cnt.clr && !cnt.inc |=> cnt.count == '0)
    else $error("counter not zero after clearing read");

  a_sat_hold: assert property (@(posedge sys_clk) disable iff (reset)
    cnt.count == MAXV && !cnt.clr |=> cnt.count == MAXV)
    else $error("saturated counter moved without a read");

  a_inc_step: assert property (@(posedge sys_clk) disable iff (reset)
    cnt.inc && !cnt.clr && cnt.count != MAXV
      |=> cnt.count == $past(cnt.count) + ONE)
    else $error("counter missed an event");
endmodule
`default_nettype wire

// ===== epc_bank.sv
// Performance counters and block interrupt summary behind AHB-Lite.
// Assumes source blocks clear their own flags when their status is read.
//
// The AHB-Lite register port is this design's own decision.
`include "epc_map.svh"
`timescale 1ns/1ps
`default_nettype none
module epc_bank (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic zeroViolationEvent,
  input wire logic hdlc2FcsErrorEvent,
  input wire logic hdlc3FcsErrorEvent,
  input wire epc_pkg::epc_byte_type spareSixFlags,
  input wire epc_pkg::epc_byte_type spareSixSrcEnable,
  input wire logic recoveredClockLost,
  input wire logic oneSecondTick,
  input wire epc_pkg::epc_byte_type hdlcFlags,
  input wire epc_pkg::epc_byte_type hdlcSrcEnable,
  input wire epc_pkg::epc_byte_type slipFlags,
  input wire epc_pkg::epc_byte_type slipSrcEnable,
  input wire epc_pkg::epc_byte_type alarmFlags,
  input wire epc_pkg::epc_byte_type alarmSrcEnable,
  input wire epc_pkg::epc_byte_type framerFlags,
  input wire epc_pkg::epc_byte_type framerSrcEnable,
  output logic irq
);
  import epc_pkg::*;

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  epc_cnt_if #(.WIDTH(`EPC_ZV_WIDTH)) zvCnt();
  epc_cnt_if #(.WIDTH(`EPC_FCS_WIDTH)) fcs2Cnt();
  epc_cnt_if #(.WIDTH(`EPC_FCS_WIDTH)) fcs3Cnt();

  epc_rur_counter #(.WIDTH(`EPC_ZV_WIDTH)) zero_violation_count (
    .sys_clk(sys_clk),
    .reset(reset),
    .cnt(zvCnt.owner)
  );
  epc_rur_counter #(.WIDTH(`EPC_FCS_WIDTH)) hdlc2_fcs_error_count (
    .sys_clk(sys_clk),
    .reset(reset),
    .cnt(fcs2Cnt.owner)
  );
  epc_rur_counter #(.WIDTH(`EPC_FCS_WIDTH)) hdlc3_fcs_error_count (
    .sys_clk(sys_clk),
    .reset(reset),
    .cnt(fcs3Cnt.owner)
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [31:0] a,
                               input logic [`EPC_ADDR_W-1:0] reg_addr);
    hit = (a[`EPC_ADDR_W-1:0] == reg_addr) && (a[31:`EPC_ADDR_W] == '0);
  endfunction

  logic take;
  logic rdTake;
  logic wrPend;
  logic [31:0] wrAddr;
  logic rdUpper;
  logic rdLower;
  logic rdFcs2;
  logic rdFcs3;
  logic rdStat;
  epc_seq_type seq;
  epc_byte_type zvLowerHold;
  epc_byte_type blockIrqEnable;
  logic [`EPC_EV_W-1:0] intStatus;
  logic [`EPC_EV_W-1:0] intMask;
  logic clkLossDetectEnable;
  epc_byte_type summary;
  epc_byte_type enabledPending;
  logic [`EPC_EV_W-1:0] events;
  logic [31:0] next_hrdata;
  logic next_irq;

  // Zero wait states: every transfer finishes in its first data cycle
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  assign take = hsel && htrans[1] && hready;
  assign rdTake = take && !hwrite;
  assign rdUpper = rdTake && hit(haddr, `EPC_ADDR_ZV_UPPER);
  assign rdLower = rdTake && hit(haddr, `EPC_ADDR_ZV_LOWER);
  assign rdFcs2 = rdTake && hit(haddr, `EPC_ADDR_FCS2);
  assign rdFcs3 = rdTake && hit(haddr, `EPC_ADDR_FCS3);
  assign rdStat = rdTake && hit(haddr, `EPC_ADDR_INT_STAT);

  // ----------------------------------------------------------------
  // Counter strobes
  // ----------------------------------------------------------------
  assign zvCnt.inc = zeroViolationEvent;
  assign fcs2Cnt.inc = hdlc2FcsErrorEvent;
  assign fcs3Cnt.inc = hdlc3FcsErrorEvent;
  // Only a lower read that follows an upper read clears the wide count
  assign zvCnt.clr = rdLower && (seq == EPC_SEQ_UPPER_DONE);
  assign fcs2Cnt.clr = rdFcs2;
  assign fcs3Cnt.clr = rdFcs3;

  // Upper read snapshots the lower byte; events until the lower read
  // are lost when it clears, so software should read the pair at once
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      seq <= EPC_SEQ_IDLE;
      zvLowerHold <= `EPC_RST_BYTE;
    end else if (rdUpper) begin
      seq <= EPC_SEQ_UPPER_DONE;
      zvLowerHold <= zvCnt.count[7:0];
    end else if (rdLower) begin
      seq <= EPC_SEQ_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // Block summary
  // ----------------------------------------------------------------
  always_comb begin
    summary = `EPC_RST_BYTE;
    summary[`EPC_BIT_SPARE6] = |spareSixFlags;
    summary[`EPC_BIT_CLKLOS] = recoveredClockLost &&
                               clkLossDetectEnable;
    summary[`EPC_BIT_ONE_SEC] = oneSecondTick;
    summary[`EPC_BIT_HDLC] = |hdlcFlags;
    summary[`EPC_BIT_SLIP] = |slipFlags;
    summary[`EPC_BIT_ALARM] = |alarmFlags;
    summary[`EPC_BIT_FRAMER] = |framerFlags;
  end

  // Bits 5 and 4 have no source layer; their block enable is the gate
  always_comb begin
    enabledPending = `EPC_RST_BYTE;
    enabledPending[`EPC_BIT_SPARE6] =
      |(spareSixFlags & spareSixSrcEnable);
    enabledPending[`EPC_BIT_CLKLOS] = summary[`EPC_BIT_CLKLOS];
    enabledPending[`EPC_BIT_ONE_SEC] = oneSecondTick;
    enabledPending[`EPC_BIT_HDLC] = |(hdlcFlags & hdlcSrcEnable);
    enabledPending[`EPC_BIT_SLIP] = |(slipFlags & slipSrcEnable);
    enabledPending[`EPC_BIT_ALARM] = |(alarmFlags & alarmSrcEnable);
    enabledPending[`EPC_BIT_FRAMER] = |(framerFlags & framerSrcEnable);
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb begin
    next_hrdata = `EPC_RST_WORD;
    if (rdUpper) begin
      next_hrdata[7:0] = zvCnt.count[15:8];
    end else if (rdLower) begin
      next_hrdata[7:0] = (seq == EPC_SEQ_UPPER_DONE) ?
                         zvLowerHold : zvCnt.count[7:0];
    end else if (rdFcs2) begin
      next_hrdata[7:0] = fcs2Cnt.count;
    end else if (rdFcs3) begin
      next_hrdata[7:0] = fcs3Cnt.count;
    end else if (rdTake && hit(haddr, `EPC_ADDR_SUMMARY)) begin
      next_hrdata[7:0] = summary;
    end else if (rdTake && hit(haddr, `EPC_ADDR_BLK_EN)) begin
      next_hrdata[7:0] = blockIrqEnable;
    end else if (rdStat) begin
      next_hrdata[`EPC_EV_W-1:0] = intStatus;
    end else if (rdTake && hit(haddr, `EPC_ADDR_INT_MASK)) begin
      next_hrdata[`EPC_EV_W-1:0] = intMask;
    end else if (rdTake && hit(haddr, `EPC_ADDR_CTRL)) begin
      next_hrdata[`EPC_CTRL_CLKLOS_DET] = clkLossDetectEnable;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      hrdata <= `EPC_RST_WORD;
    end else if (rdTake) begin
      hrdata <= next_hrdata;
    end
  end

  // ----------------------------------------------------------------
  // Writes
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wrPend <= 1'b0;
      wrAddr <= `EPC_RST_WORD;
    end else begin
      wrPend <= take && hwrite;
      if (take) begin
        wrAddr <= haddr;
      end
    end
  end

  // Summary and counter addresses are not decoded for writes
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      blockIrqEnable <= `EPC_RST_BYTE;
      intMask <= `EPC_RST_EV;
      clkLossDetectEnable <= 1'b0;
    end else if (wrPend) begin
      if (hit(wrAddr, `EPC_ADDR_BLK_EN)) begin
        blockIrqEnable <= hwdata[7:0];
        blockIrqEnable[`EPC_BIT_RSVD] <= 1'b0;
      end
      if (hit(wrAddr, `EPC_ADDR_INT_MASK)) begin
        intMask <= hwdata[`EPC_EV_W-1:0];
      end
      if (hit(wrAddr, `EPC_ADDR_CTRL)) begin
        clkLossDetectEnable <= hwdata[`EPC_CTRL_CLKLOS_DET];
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  always_comb begin
    events = `EPC_RST_EV;
    events[`EPC_EV_ZV] = zeroViolationEvent;
    events[`EPC_EV_FCS2] = hdlc2FcsErrorEvent;
    events[`EPC_EV_FCS3] = hdlc3FcsErrorEvent;
  end

  // Event wins over the clearing read in the same cycle
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      intStatus <= `EPC_RST_EV;
    end else begin
      intStatus <= (rdStat ? `EPC_RST_EV : intStatus) | events;
    end
  end

  assign next_irq = (|(intStatus & intMask)) ||
                    (|(blockIrqEnable & enabledPending));

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_lower_snapshot: assert property (
    @(posedge sys_clk) disable iff (reset)
    rdLower && seq == EPC_SEQ_UPPER_DONE
      |=> hrdata[7:0] == $past(zvLowerHold))
    else $error("lower byte not taken from the snapshot");

  a_upper_capture: assert property (
    @(posedge sys_clk) disable iff (reset)
    rdUpper |=> zvLowerHold == $past(zvCnt.count[7:0]))
    else $error("upper read did not capture the lower byte");

  a_pair_clears: assert property (
    @(posedge sys_clk) disable iff (reset)
    rdLower && seq == EPC_SEQ_UPPER_DONE && !zeroViolationEvent
      |=> zvCnt.count == '0 && seq == EPC_SEQ_IDLE)
    else $error("upper then lower read did not clear the count");

  a_lone_lower: assert property (
    @(posedge sys_clk) disable iff (reset)
    rdLower && seq == EPC_SEQ_IDLE && !zeroViolationEvent
      |=> zvCnt.count == $past(zvCnt.count))
    else $error("lower read without upper read cleared the count");

  a_fcs_read_clear: assert property (
    @(posedge sys_clk) disable iff (reset)
    rdFcs2 && !hdlc2FcsErrorEvent
      |=> fcs2Cnt.count == '0 && hrdata[31:8] == '0)
    else $error("check-sequence counter not cleared by read");

  a_clkloss_gate: assert property (
    @(posedge sys_clk) disable iff (reset)
    rdTake && hit(haddr, `EPC_ADDR_SUMMARY) && !clkLossDetectEnable
      |=> !hrdata[`EPC_BIT_CLKLOS])
    else $error("clock-loss summary ignores detection enable");

  a_summary_ro: assert property (
    @(posedge sys_clk) disable iff (reset)
    rdTake && hit(haddr, `EPC_ADDR_SUMMARY)
      |=> hrdata[7:0] == $past(summary) && hrdata[`EPC_BIT_RSVD] == 1'b0)
    else $error("summary read does not match source flags");

  a_irq_masked: assert property (
    @(posedge sys_clk) disable iff (reset)
    blockIrqEnable == '0 && intMask == '0 ##1 blockIrqEnable == '0
      |-> !irq)
    else $error("interrupt raised with every enable off");

  a_status_sticky: assert property (
    @(posedge sys_clk) disable iff (reset)
    events[`EPC_EV_ZV] ##1 !rdStat[*2] |-> intStatus[`EPC_EV_ZV])
    else $error("status bit lost before it was read");
endmodule
`default_nettype wire

// ===== epc_host_model.sv
// Host processor model: single-word AHB-Lite master for the counter bank.
// Assumes one slave whose hreadyout is fed back as hready.
`timescale 1ns/1ps
`default_nettype none
module epc_host_model (
  input wire logic sys_clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial begin
    hsel = 1'b1;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
  end
  // ----------------------------------------------------------------------
  // One transfer
  // ----------------------------------------------------------------------
  // Waits on hready with no cycle count assumed; the bench watchdog ends
  // a hang. Upper-before-lower ordering is the caller's duty
  task automatic xfer(input logic [31:0] a, input logic w,
                      input logic [31:0] wd, output logic [31:0] d);
    @(posedge sys_clk);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge sys_clk);
    while (hready !== 1'b1) @(posedge sys_clk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge sys_clk);
    while (hready !== 1'b1) @(posedge sys_clk);
    d = hrdata;
  endtask
endmodule
`default_nettype wire

// ===== epc_testbench.sv
// Self-checking bench for the counter bank and interrupt summary.
// Assumes the host model as bus master and zero-wait slave answers.
`include "epc_map.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import epc_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic hsel, hwrite, hreadyout, hresp, irq, clkLost, one_second_tick_pending;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [2:0] evs = 3'h0;
  epc_byte_type flg [5] = '{default: 8'h00};
  epc_byte_type en [5] = '{default: 8'h00};
  int errTotal = 0;
  int comparisons = 0;
  always #20 sys_clk = ~sys_clk;
  initial begin
    clkLost = 1'b0;
    one_second_tick_pending = 1'b0;
  end
  epc_host_model epc_host_model_inst (.sys_clk(sys_clk), .hready(hreadyout),
    .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  epc_bank epc_bank_inst (.sys_clk(sys_clk), .reset(reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .zeroViolationEvent(evs[0]),
    .hdlc2FcsErrorEvent(evs[1]), .hdlc3FcsErrorEvent(evs[2]),
    .spareSixFlags(flg[0]), .spareSixSrcEnable(en[0]),
    .recoveredClockLost(clkLost),
    .oneSecondTick(one_second_tick_pending), .hdlcFlags(flg[1]), .hdlcSrcEnable(en[1]),
    .slipFlags(flg[2]), .slipSrcEnable(en[2]), .alarmFlags(flg[3]),
    .alarmSrcEnable(en[3]), .framerFlags(flg[4]),
    .framerSrcEnable(en[4]), .irq(irq));
  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errTotal++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] d;
    epc_host_model_inst.xfer(a, 1'b0, 32'h0, d);
    chk($sformatf("read %h", a), d, exp);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    logic [31:0] d;
    epc_host_model_inst.xfer(a, 1'b1, v, d);
  endtask
  // Events sampled high at exactly n edges
  task automatic pulse(input logic [2:0] m, input int n);
    @(posedge sys_clk);
    evs <= m;
    repeat (n) @(posedge sys_clk);
    evs <= 3'h0;
  endtask
  task automatic irq_is(input logic exp);
    repeat (2) @(posedge sys_clk);
    chk("irq", {31'h0, irq}, {31'h0, exp});
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, errTotal);
    if (errTotal == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic test_reset;
    rd(`EPC_ADDR_ZV_UPPER, 32'h0);
    rd(`EPC_ADDR_ZV_LOWER, 32'h0);
    rd(`EPC_ADDR_FCS2, 32'h0);
    rd(`EPC_ADDR_FCS3, 32'h0);
    rd(`EPC_ADDR_SUMMARY, 32'h0);
    rd(32'h0000_0ffc, 32'h0);
    chk("irq idle", {31'h0, irq}, 32'h0);
    chk("hresp", {31'h0, hresp}, 32'h0);
    $display("test_reset done");
  endtask
  task automatic test_zero_count;
    pulse(3'h1, 300);
    rd(`EPC_ADDR_ZV_UPPER, 32'h01);
    pulse(3'h1, 2);
    rd(`EPC_ADDR_ZV_LOWER, 32'h2c);
    rd(`EPC_ADDR_ZV_UPPER, 32'h0);
    rd(`EPC_ADDR_ZV_LOWER, 32'h0);
    // A lone lower read shows the live count and leaves it standing
    pulse(3'h1, 3);
    rd(`EPC_ADDR_ZV_LOWER, 32'h03);
    rd(`EPC_ADDR_ZV_LOWER, 32'h03);
    rd(`EPC_ADDR_ZV_UPPER, 32'h0);
    rd(`EPC_ADDR_ZV_LOWER, 32'h03);
    rd(`EPC_ADDR_ZV_LOWER, 32'h0);
    $display("test_zero_count done");
  endtask
  task automatic test_fcs;
    pulse(3'h2, 3);
    pulse(3'h4, 5);
    rd(`EPC_ADDR_FCS2, 32'h03);
    rd(`EPC_ADDR_FCS3, 32'h05);
    rd(`EPC_ADDR_FCS2, 32'h0);
    rd(`EPC_ADDR_FCS3, 32'h0);
    wr(`EPC_ADDR_FCS2, 32'h55);
    rd(`EPC_ADDR_FCS2, 32'h0);
    pulse(3'h6, 260);
    rd(`EPC_ADDR_FCS2, 32'hff);
    rd(`EPC_ADDR_FCS3, 32'hff);
    rd(`EPC_ADDR_FCS2, 32'h0);
    $display("test_fcs done");
  endtask
  task automatic test_summary;
    int bitOf [5] = '{7, 3, 2, 1, 0};
    logic [31:0] expBit;
    en <= '{default: 8'hff};
    for (int i = 0; i < 5; i++) begin
      @(posedge sys_clk);
      expBit = 32'h1 << bitOf[i];
      flg[i] <= 8'h10;
      rd(`EPC_ADDR_SUMMARY, expBit);
      wr(`EPC_ADDR_SUMMARY, 32'h0);
      rd(`EPC_ADDR_SUMMARY, expBit);
      @(posedge sys_clk);
      flg[i] <= 8'h00;
      rd(`EPC_ADDR_SUMMARY, 32'h0);
    end
    @(posedge sys_clk);
    clkLost <= 1'b1;
    rd(`EPC_ADDR_SUMMARY, 32'h0);
    wr(`EPC_ADDR_CTRL, 32'h1);
    rd(`EPC_ADDR_SUMMARY, 32'h20);
    @(posedge sys_clk);
    clkLost <= 1'b0;
    one_second_tick_pending <= 1'b1;
    rd(`EPC_ADDR_SUMMARY, 32'h10);
    @(posedge sys_clk);
    one_second_tick_pending <= 1'b0;
    $display("test_summary done");
  endtask
  task automatic test_irq;
    rd(`EPC_ADDR_INT_STAT, 32'h07);
    rd(`EPC_ADDR_INT_STAT, 32'h0);
    @(posedge sys_clk);
    en[4] <= 8'h00;
    flg[4] <= 8'h01;
    wr(`EPC_ADDR_BLK_EN, 32'h01);
    irq_is(1'b0);
    en[4] <= 8'h01;
    irq_is(1'b1);
    wr(`EPC_ADDR_BLK_EN, 32'h0);
    irq_is(1'b0);
    flg[4] <= 8'h00;
    one_second_tick_pending <= 1'b1;
    wr(`EPC_ADDR_BLK_EN, 32'h10);
    irq_is(1'b1);
    one_second_tick_pending <= 1'b0;
    wr(`EPC_ADDR_INT_MASK, 32'h01);
    pulse(3'h4, 1);
    irq_is(1'b0);
    pulse(3'h1, 1);
    irq_is(1'b1);
    rd(`EPC_ADDR_INT_STAT, 32'h05);
    irq_is(1'b0);
    rd(`EPC_ADDR_INT_STAT, 32'h0);
    $display("test_irq done");
  endtask
  // ----------------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    test_reset();
    test_zero_count();
    test_fcs();
    test_summary();
    test_irq();
    finish_test();
  end
  // The whole run needs well under 3000 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    errTotal++;
    finish_test();
  end
endmodule
`default_nettype wire
